/* File: hdl/sr1p_pkg.sv */
// Constants for the persistent status register one block
package sr1p_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_WRITE_REGISTERS = 8'h01; // write_registers_cmd
    localparam logic [7:0] CMD_READ_ANY_REG = 8'h65; // read_any_reg_cmd
    localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71; // write_any_reg_cmd
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;

    // ==========================================================
    // Any-register addresses (24-bit)
    localparam logic [23:0] ADDR_STATUS_ONE_PERSISTENT = 24'h000000;
    localparam logic [23:0] ADDR_CONFIG_ONE_PERSISTENT = 24'h000002;
    localparam logic [23:0] ADDR_STATUS_ONE_LIVE = 24'h800000;
    localparam logic [23:0] ADDR_CONFIG_ONE_LIVE = 24'h800002;

    // ==========================================================
    // Field positions
    localparam int BIT_REG_LOCK = 7;
    localparam int BIT_PROG_FAULT = 6;
    localparam int BIT_ERASE_FAULT = 5;
    localparam int BIT_GUARD_HI = 4;
    localparam int BIT_GUARD_LO = 2;
    localparam int BIT_WRITE_LATCH = 1;
    localparam int BIT_BUSY = 0;
    localparam int BIT_GUARD_VOLATILE_SELECT = 3;

    // ==========================================================
    // Shipped persistent values
    localparam logic RST_REG_LOCK = 1'b0;
    localparam logic PROG_FAULT_DEFAULT = 1'b0;
    localparam logic ERASE_FAULT_DEFAULT = 1'b0;
    localparam logic [2:0] RST_GUARD = 3'h0;
    localparam logic [2:0] GUARD_ALL_ONES = 3'h7;
    localparam logic WRITE_LATCH_DEFAULT = 1'b0;
    localparam logic BUSY_FLAG_DEFAULT = 1'b0;
    localparam logic [7:0] RST_CONFIG_ONE = 8'h00;

    // ==========================================================
    // Link framing counts
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] BYTES_CMD_ONLY = 3'h1;
    localparam logic [2:0] BYTES_WRR_ONE = 3'h2;
    localparam logic [2:0] BYTES_WRR_TWO = 3'h3;
    localparam logic [2:0] BYTES_ANY_DATA = 3'h4;
    localparam logic [2:0] BYTES_ANY_DONE = 3'h5;
    localparam logic [2:0] BYTES_MAX = 3'h7;

    // Frame phase
    typedef enum logic [1:0] {
        SR1P_IDLE,
        SR1P_ACTIVE
    } sr1p_phase_t;

endpackage

/* File: hdl/sr1p_status_one_persistent.sv */
// Persistent status register one with lock gating behind a serial command link
// Function
// RULE_01: Decode write-registers 01h, read-any 65h and write-any 71h for this register.
// RULE_02: Lock set and protect pin low: ignore writes to status one and config one.
// RULE_03: Protect pin high: writes to status one and config one are accepted.
// RULE_04: Lock clear: protect pin ignored, writes allowed.
// RULE_05: Protect pin never blocks writes to other registers.
// RULE_06: Live lock bit 7 mirrors the persistent lock bit with no delay.
// RULE_07: Persistent bit 6 defaults live program fault, read-only, shipped 0.
// RULE_08: Persistent bit 5 defaults live erase fault, read-only, shipped 0.
// RULE_09: Select clear: write-registers programs persistent guard bits and copies to live.
// RULE_10: Select set: write-registers updates live guard bits only.
// RULE_11: Switching to volatile guard sets persistent guard to 111b, then frozen.
// RULE_12: Any governing guard bit set refuses program and erase in the region.
// RULE_13: Whole-array erase allowed only when all governing guard bits are 0.
// RULE_14: Persistent bit 1 defaults the write latch and rejects host programming.
// RULE_15: Persistent bit 0 defaults the busy flag and rejects host programming.
// RULE_16: Power-on, hardware or software reset copies persistent into live registers.
// RULE_17: Persistent writes reprogram the persistent copy then refresh the live copy.
// RULE_18: Host sets the write latch before any write, else the write is ignored.
// RULE_19: Protection is judged at command acceptance; a refused write changes nothing.
`timescale 1ns/1ps

module sr1p_status_one_persistent
    import sr1p_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    input wire logic hw_reset_n_in,
    input wire logic soft_reset_in,
    output logic so_out,
    output logic so_oe_out,
    output logic [2:0] guard_bits_out,
    output logic guard_active_out,
    output logic bulk_erase_allowed_out,
    output logic [7:0] status_one_persistent_out,
    output logic [7:0] status_one_live_out,
    output logic [7:0] config_one_live_out
);

    // ==========================================================
    // Pin synchronisers
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic sck_prev_q;
    logic cs_act_prev_q;

    // Two flops on every pin except clk_in, rst_n_in and soft_reset_in; stage one feeds stage two only
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // Idle pin levels: deselected, clock low, so no false edge after reset
            sync1_q <= 5'h1a;
            sync2_q <= 5'h1a;
        end
        else
        begin
            sync1_q <= {hw_reset_n_in, wp_n_in, si_in, cs_n_in, sck_in};
            sync2_q <= sync1_q;
        end
    end

    wire logic sck_s = sync2_q[0];
    wire logic cs_act = ~sync2_q[1];
    wire logic si_s = sync2_q[2];
    wire logic wp_high = sync2_q[3];
    wire logic hw_reset_act = ~sync2_q[4];

    // Edge history
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sck_prev_q <= 1'b0;
            cs_act_prev_q <= 1'b0;
        end
        else
        begin
            sck_prev_q <= sck_s;
            cs_act_prev_q <= cs_act;
        end
    end

    wire logic sck_rise = cs_act & sck_s & ~sck_prev_q;
    wire logic sck_fall = cs_act & ~sck_s & sck_prev_q;
    wire logic frame_end = cs_act_prev_q & ~cs_act;
    wire logic live_reload = hw_reset_act | soft_reset_in; // RULE_16

    // ==========================================================
    // Frame shifter
    sr1p_phase_t phase_q;
    sr1p_phase_t phase_d;
    logic [6:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic [2:0] byte_cnt_q;
    logic [7:0] cmd_q;
    logic [23:0] addr_q;
    logic [7:0] data0_q;
    logic [7:0] data1_q;
    logic so_q;

    wire logic [7:0] rx_byte = {shift_q, si_s};
    wire logic byte_done = sck_rise & (bit_cnt_q == LAST_BIT);
    wire logic is_wrr = (cmd_q == CMD_WRITE_REGISTERS); // RULE_01
    wire logic is_read_any_reg_cmd = (cmd_q == CMD_READ_ANY_REG); // RULE_01
    wire logic is_write_any_reg_cmd = (cmd_q == CMD_WRITE_ANY_REG); // RULE_01
    wire logic read_phase = is_read_any_reg_cmd & (byte_cnt_q >= BYTES_ANY_DATA);

    // Phase follows chip select
    always_comb
    begin
        phase_d = phase_q;
        unique case (phase_q)
            SR1P_IDLE: if (cs_act && !live_reload) phase_d = SR1P_ACTIVE;
            SR1P_ACTIVE: if (!cs_act || live_reload) phase_d = SR1P_IDLE;
        endcase
    end

    wire logic active = (phase_q == SR1P_ACTIVE) & cs_act;

    // Bit and byte capture on sampled clock rises
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            phase_q <= SR1P_IDLE;
            shift_q <= 7'h00;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
        end
        else
        begin
            phase_q <= phase_d;
            if (!active)
            begin
                bit_cnt_q <= 3'h0;
                byte_cnt_q <= 3'h0;
            end
            else if (sck_rise)
            begin
                shift_q <= rx_byte[6:0];
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (byte_done && byte_cnt_q != BYTES_MAX)
                    byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    // Command, address and data bytes by position
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cmd_q <= 8'h00;
            addr_q <= 24'h000000;
            data0_q <= 8'h00;
            data1_q <= 8'h00;
        end
        else if (active && byte_done)
        begin
            if (byte_cnt_q == 3'h0)
                cmd_q <= rx_byte;
            else if (is_wrr && byte_cnt_q == 3'h1)
                data0_q <= rx_byte;
            else if (is_wrr && byte_cnt_q == 3'h2)
                data1_q <= rx_byte;
            else if ((is_read_any_reg_cmd || is_write_any_reg_cmd) && byte_cnt_q < BYTES_ANY_DATA)
                addr_q <= {addr_q[15:0], rx_byte};
            else if (is_write_any_reg_cmd && byte_cnt_q == BYTES_ANY_DATA)
                data0_q <= rx_byte;
        end
    end

    // ==========================================================
    // Register state
    logic reg_lock_persistent_q;
    logic [2:0] guard_persistent_q;
    logic [7:0] config_one_persistent_q;
    logic [7:0] config_one_live_q;
    logic [2:0] guard_live_q;
    logic prog_fault_q;
    logic erase_fault_q;
    logic write_enable_latch_q;
    logic write_in_progress_q;
    logic reg_lock_persistent_d;
    logic [2:0] guard_persistent_d;
    logic [7:0] config_one_persistent_d;
    logic [7:0] config_one_live_d;
    logic [2:0] guard_live_d;
    logic write_enable_latch_d;

    wire logic guard_volatile_select = config_one_persistent_q[BIT_GUARD_VOLATILE_SELECT];
    wire logic reg_lock_live = reg_lock_persistent_q; // RULE_06

    // Persistent and live images; read-only persistent bits are fixed defaults
    assign status_one_persistent_out = {reg_lock_persistent_q, PROG_FAULT_DEFAULT,
        ERASE_FAULT_DEFAULT, guard_persistent_q, WRITE_LATCH_DEFAULT,
        BUSY_FLAG_DEFAULT}; // RULE_07 RULE_08 RULE_14 RULE_15
    assign status_one_live_out = {reg_lock_live, prog_fault_q, erase_fault_q, guard_live_q,
        write_enable_latch_q, write_in_progress_q};
    assign config_one_live_out = config_one_live_q;

    // Write gating judged at frame end, when the command is accepted
    wire logic hw_locked = reg_lock_persistent_q & ~wp_high; // RULE_02 RULE_03 RULE_04
    wire logic wrr_go = frame_end & is_wrr & (byte_cnt_q >= BYTES_WRR_ONE)
        & write_enable_latch_q & ~hw_locked; // RULE_18 RULE_19
    wire logic wrr_cfg = wrr_go & (byte_cnt_q >= BYTES_WRR_TWO);
    wire logic write_any_reg_cmd_frame = frame_end & is_write_any_reg_cmd & (byte_cnt_q >= BYTES_ANY_DONE)
        & write_enable_latch_q; // RULE_18
    wire logic hit_snv = (addr_q == ADDR_STATUS_ONE_PERSISTENT);
    wire logic hit_sv = (addr_q == ADDR_STATUS_ONE_LIVE);
    wire logic hit_cnv = (addr_q == ADDR_CONFIG_ONE_PERSISTENT);
    wire logic hit_cv = (addr_q == ADDR_CONFIG_ONE_LIVE);
    // Only status one and config one are behind the protect pin here
    wire logic write_any_reg_cmd_go = write_any_reg_cmd_frame & (hit_snv | hit_sv | hit_cnv | hit_cv)
        & ~hw_locked; // RULE_05 RULE_19
    wire logic [7:0] status_wdata = data0_q;
    wire logic [7:0] config_wdata = wrr_cfg ? data1_q : data0_q;
    wire logic status_nv_wr = wrr_go | (write_any_reg_cmd_go & hit_snv);
    wire logic status_v_wr = wrr_go | (write_any_reg_cmd_go & hit_sv);
    wire logic config_nv_wr = wrr_cfg | (write_any_reg_cmd_go & hit_cnv);
    wire logic config_v_wr = write_any_reg_cmd_go & hit_cv;
    wire logic select_turn_on = config_nv_wr & ~guard_volatile_select
        & config_wdata[BIT_GUARD_VOLATILE_SELECT];

    // Next register values
    always_comb
    begin
        reg_lock_persistent_d = reg_lock_persistent_q;
        guard_persistent_d = guard_persistent_q;
        config_one_persistent_d = config_one_persistent_q;
        config_one_live_d = config_one_live_q;
        guard_live_d = guard_live_q;
        write_enable_latch_d = write_enable_latch_q;
        if (status_nv_wr)
        begin
            reg_lock_persistent_d = status_wdata[BIT_REG_LOCK]; // RULE_17
            if (!guard_volatile_select)
            begin
                guard_persistent_d = status_wdata[BIT_GUARD_HI:BIT_GUARD_LO]; // RULE_09
                guard_live_d = status_wdata[BIT_GUARD_HI:BIT_GUARD_LO]; // RULE_09 RULE_17
            end
        end
        if (status_v_wr && guard_volatile_select && !(write_any_reg_cmd_go && hit_snv))
            guard_live_d = status_wdata[BIT_GUARD_HI:BIT_GUARD_LO]; // RULE_10
        if (config_nv_wr)
        begin
            // Select bit can only be set, never cleared
            config_one_persistent_d = config_wdata;
            config_one_persistent_d[BIT_GUARD_VOLATILE_SELECT] = guard_volatile_select
                | config_wdata[BIT_GUARD_VOLATILE_SELECT];
            config_one_live_d = config_one_persistent_d; // RULE_17
        end
        if (config_v_wr)
        begin
            config_one_live_d = config_wdata;
            config_one_live_d[BIT_GUARD_VOLATILE_SELECT] = guard_volatile_select;
        end
        if (select_turn_on)
            guard_persistent_d = GUARD_ALL_ONES; // RULE_11
        if (frame_end && cmd_q == CMD_WRITE_ENABLE && byte_cnt_q >= BYTES_CMD_ONLY)
            write_enable_latch_d = 1'b1;
        else if (frame_end && cmd_q == CMD_WRITE_DISABLE && byte_cnt_q >= BYTES_CMD_ONLY)
            write_enable_latch_d = 1'b0;
        else if (wrr_go || write_any_reg_cmd_go)
            write_enable_latch_d = 1'b0;
    end

    // Persistent copies survive hardware and software reset
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            reg_lock_persistent_q <= RST_REG_LOCK;
            guard_persistent_q <= RST_GUARD;
            config_one_persistent_q <= RST_CONFIG_ONE;
        end
        else if (!live_reload)
        begin
            reg_lock_persistent_q <= reg_lock_persistent_d;
            guard_persistent_q <= guard_persistent_d;
            config_one_persistent_q <= config_one_persistent_d;
        end
    end

    // Live copies reload from persistent on any reset
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            config_one_live_q <= RST_CONFIG_ONE;
            guard_live_q <= RST_GUARD;
            prog_fault_q <= PROG_FAULT_DEFAULT;
            erase_fault_q <= ERASE_FAULT_DEFAULT;
            write_enable_latch_q <= WRITE_LATCH_DEFAULT;
            write_in_progress_q <= BUSY_FLAG_DEFAULT;
        end
        else if (live_reload)
        begin
            config_one_live_q <= config_one_persistent_q; // RULE_16
            guard_live_q <= guard_persistent_q; // RULE_16
            prog_fault_q <= PROG_FAULT_DEFAULT; // RULE_07
            erase_fault_q <= ERASE_FAULT_DEFAULT; // RULE_08
            write_enable_latch_q <= WRITE_LATCH_DEFAULT; // RULE_14
            write_in_progress_q <= BUSY_FLAG_DEFAULT; // RULE_15
        end
        else
        begin
            config_one_live_q <= config_one_live_d;
            guard_live_q <= guard_live_d;
            write_enable_latch_q <= write_enable_latch_d;
        end
    end

    // ==========================================================
    // Protection outputs
    assign guard_bits_out = guard_volatile_select ? guard_live_q : guard_persistent_q;
    assign guard_active_out = |guard_bits_out; // RULE_12
    assign bulk_erase_allowed_out = ~guard_active_out; // RULE_13

    // ==========================================================
    // Read-any data path
    wire logic [7:0] read_byte = hit_snv ? status_one_persistent_out :
        hit_sv ? status_one_live_out :
        hit_cnv ? config_one_persistent_q :
        hit_cv ? config_one_live_q : 8'h00;

    // Output bit changes on sampled clock falls, most significant first
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            so_q <= 1'b0;
        else if (!active)
            so_q <= 1'b0;
        else if (sck_fall && read_phase)
            so_q <= read_byte[~bit_cnt_q]; // RULE_01
    end

    assign so_out = so_q;
    assign so_oe_out = active & read_phase;

endmodule // sr1p_status_one_persistent

/* File: tb/sr1p_monitor.sv */
// Port checker for the persistent status register one block
`timescale 1ns/1ps

module sr1p_monitor (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    input wire logic hw_reset_n_in,
    input wire logic soft_reset_in,
    input wire logic so_out,
    input wire logic so_oe_out,
    input wire logic [2:0] guard_bits_out,
    input wire logic guard_active_out,
    input wire logic bulk_erase_allowed_out,
    input wire logic [7:0] status_one_persistent_out,
    input wire logic [7:0] status_one_live_out,
    input wire logic [7:0] config_one_live_out
);
    // ==========================================================
    // Clocking and sequences
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_locked;
        (status_one_persistent_out[7] && !wp_n_in) [*4];
    endsequence
    sequence s_deselected;
        cs_n_in [*3];
    endsequence

    // ==========================================================
    // Properties
    property p_lock_mirror;
        status_one_live_out[7] == status_one_persistent_out[7];
    endproperty
    property p_fixed_bits;
        status_one_persistent_out[6:5] == 2'h0 && status_one_persistent_out[1:0] == 2'h0;
    endproperty
    property p_guard_src;
        guard_bits_out == (config_one_live_out[3] ? status_one_live_out[4:2]
            : status_one_persistent_out[4:2]);
    endproperty
    property p_guard_active;
        guard_active_out == (guard_bits_out != 3'h0);
    endproperty
    property p_bulk;
        bulk_erase_allowed_out == (guard_bits_out == 3'h0);
    endproperty
    property p_volatile_ones;
        config_one_live_out[3] |-> status_one_persistent_out[4:2] == 3'h7;
    endproperty
    property p_select_sticky;
        config_one_live_out[3] |=> config_one_live_out[3];
    endproperty
    property p_locked_hold;
        s_locked |=> $stable(status_one_persistent_out);
    endproperty
    property p_so_release;
        s_deselected |-> !so_oe_out;
    endproperty
    property p_soft_reload;
        soft_reset_in |=> status_one_live_out[6:5] == 2'h0 && status_one_live_out[1:0] == 2'h0
            && status_one_live_out[4:2] == $past(status_one_persistent_out[4:2]);
    endproperty

    // ==========================================================
    // Assertions
    a_lock_mirror: assert property (p_lock_mirror) else $error("lock mirror differs");
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit changed");
    a_guard_src: assert property (p_guard_src) else $error("guard source wrong");
    a_guard_active: assert property (p_guard_active) else $error("guard active wrong");
    a_bulk: assert property (p_bulk) else $error("bulk erase gate wrong");
    a_volatile_ones: assert property (p_volatile_ones) else $error("guard not all ones");
    a_select_sticky: assert property (p_select_sticky) else $error("select bit cleared");
    a_locked_hold: assert property (p_locked_hold) else $error("locked write taken");
    a_so_release: assert property (p_so_release) else $error("so driven when idle");
    a_soft_reload: assert property (p_soft_reload) else $error("reload wrong");
endmodule // sr1p_monitor

bind sr1p_status_one_persistent sr1p_monitor i_mon (.clk_in, .rst_n_in, .sck_in, .cs_n_in,
    .si_in, .wp_n_in, .hw_reset_n_in, .soft_reset_in, .so_out, .so_oe_out, .guard_bits_out,
    .guard_active_out, .bulk_erase_allowed_out, .status_one_persistent_out,
    .status_one_live_out, .config_one_live_out);

/* File: tb/sr1p_host_model.sv */
// Host serial controller model, mode 0, msb first
`timescale 1ns/1ps

module sr1p_host_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in
);
    // Idle pins: deselected, clock still
    initial
    begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end

    // One frame of nb bytes; rx keeps the last eight bits read
    task automatic frame(input int nb, input logic [39:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        cs_n_out = 1'b0;
        for (int i = nb * 8 - 1; i >= 0; i--)
        begin
            si_out = tx[i];
            #160 sck_out = 1'b1;
            rx = {rx[6:0], so_in};
            #160 sck_out = 1'b0;
        end
        #160 cs_n_out = 1'b1;
        si_out = ~si_out; // Released line keeps no stale value
        #200;
    endtask
endmodule // sr1p_host_model

/* File: tb/sr1p_status_one_persistent_tb.sv */
// Self-checking bench for the persistent status register one block
`timescale 1ns/1ps

module sr1p_status_one_persistent_tb
    import sr1p_pkg::*;
;
    logic clk_in, rst_n_in, sck_in, cs_n_in, si_in, wp_n_in, hw_reset_n_in, soft_reset_in;
    logic so_out, so_oe_out, guard_active_out, bulk_erase_allowed_out;
    logic [2:0] guard_bits_out;
    logic [7:0] status_one_persistent_out, status_one_live_out, config_one_live_out, rx;
    int n_fail, check_count;

    // ==========================================================
    // Design, host and clock
    sr1p_status_one_persistent i_dut (.clk_in, .rst_n_in, .sck_in, .cs_n_in, .si_in,
        .wp_n_in, .hw_reset_n_in, .soft_reset_in, .so_out, .so_oe_out, .guard_bits_out,
        .guard_active_out, .bulk_erase_allowed_out, .status_one_persistent_out,
        .status_one_live_out, .config_one_live_out);
    sr1p_host_model i_host (.sck_out(sck_in), .cs_n_out(cs_n_in), .si_out(si_in),
        .so_in(so_out));
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Optional write enable, one frame, then wait out sync and update
    task automatic wr(input int nb, input logic [39:0] tx, input logic en);
        logic [7:0] unused;
        if (en)
            i_host.frame(1, {32'h0, CMD_WRITE_ENABLE}, unused);
        i_host.frame(nb, tx, unused);
        repeat (6) @(negedge clk_in);
    endtask
    task automatic write_registers_cmd(input logic [7:0] d);
        wr(2, {24'h0, CMD_WRITE_REGISTERS, d}, 1'b1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_basic();
        chk("persistent", status_one_persistent_out, 8'h00);
        chk("live", status_one_live_out, 8'h00);
        chk("bulk", {7'h0, bulk_erase_allowed_out}, 8'h01);
        wr(2, {24'h0, CMD_WRITE_REGISTERS, 8'h1c}, 1'b0);
        chk("no latch", status_one_persistent_out, 8'h00);
        write_registers_cmd(8'hff);
        chk("persistent", status_one_persistent_out, 8'h9c);
        chk("live", status_one_live_out, 8'h9c);
        chk("guard", {5'h0, guard_bits_out}, 8'h07);
        chk("active", {7'h0, guard_active_out}, 8'h01);
        chk("bulk", {7'h0, bulk_erase_allowed_out}, 8'h00);
    endtask
    task automatic t_locked();
        @(negedge clk_in);
        wp_n_in = 1'b0;
        write_registers_cmd(8'h00);
        wr(5, {CMD_WRITE_ANY_REG, ADDR_STATUS_ONE_PERSISTENT, 8'h00}, 1'b1);
        chk("locked", status_one_persistent_out, 8'h9c);
        chk("latch kept", status_one_live_out, 8'h9e);
        i_host.frame(5, {CMD_READ_ANY_REG, ADDR_STATUS_ONE_PERSISTENT, 8'h00}, rx);
        chk("read any", rx, 8'h9c);
        wr(1, {32'h0, CMD_WRITE_DISABLE}, 1'b0);
        chk("latch off", status_one_live_out, 8'h9c);
        @(negedge clk_in);
        wp_n_in = 1'b1;
        write_registers_cmd(8'h84);
        chk("pin high", status_one_persistent_out, 8'h84);
        write_registers_cmd(8'h00);
        @(negedge clk_in);
        wp_n_in = 1'b0;
        wr(5, {CMD_WRITE_ANY_REG, ADDR_STATUS_ONE_PERSISTENT, 8'h88}, 1'b1);
        chk("unlocked", status_one_persistent_out, 8'h88);
        @(negedge clk_in);
        wp_n_in = 1'b1;
    endtask
    task automatic t_volatile();
        wr(3, {16'h0, CMD_WRITE_REGISTERS, 8'h00, 8'h08}, 1'b1);
        chk("select", {7'h0, config_one_live_out[3]}, 8'h01);
        chk("all ones", status_one_persistent_out, 8'h1c);
        write_registers_cmd(8'h08);
        chk("persistent", status_one_persistent_out, 8'h1c);
        chk("live guard", {5'h0, status_one_live_out[4:2]}, 8'h02);
        chk("guard", {5'h0, guard_bits_out}, 8'h02);
        wr(5, {CMD_WRITE_ANY_REG, ADDR_STATUS_ONE_PERSISTENT, 8'h00}, 1'b1);
        chk("frozen", status_one_persistent_out, 8'h1c);
    endtask
    task automatic t_reload();
        for (int k = 0; k < 2; k++)
        begin
            write_registers_cmd(8'h08);
            soft_reset_in = (k == 0);
            hw_reset_n_in = (k == 0);
            repeat (3) @(negedge clk_in);
            soft_reset_in = 1'b0;
            hw_reset_n_in = 1'b1;
            repeat (4) @(negedge clk_in);
            chk("reload", status_one_live_out, 8'h1c);
        end
    endtask

    // ==========================================================
    // Main sequence and hang guard
    initial
    begin
        n_fail = 0;
        check_count = 0;
        rst_n_in = 1'b0;
        wp_n_in = 1'b1;
        hw_reset_n_in = 1'b1;
        soft_reset_in = 1'b0;
        repeat (5) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_basic();
        t_locked();
        t_volatile();
        t_reload();
        conclude();
    end
    initial
    begin
        #1000000;
        n_fail++;
        conclude();
    end
endmodule // sr1p_status_one_persistent_tb
